// ### tws_pkg.sv
// Package with constants and carrier types for the tape write-start and readout control.
package tws_pkg;

  // Clock rate in kHz and the documented times.
  localparam int unsigned CLK_KHZ          = 100000;
  localparam int unsigned SHORT_GAP_US     = 8700;
  localparam int unsigned LONG_GAP_US      = 22700;
  localparam int unsigned SHORT_GAP_CYCLES = SHORT_GAP_US * (CLK_KHZ / 1000);
  localparam int unsigned LONG_GAP_CYCLES  = LONG_GAP_US * (CLK_KHZ / 1000);
  localparam int unsigned START_PULSE_NS   = 500;
  localparam int unsigned START_CYCLES     = (START_PULSE_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int unsigned DRIVE_US         = 1;
  localparam int unsigned DRIVE_CYCLES     = DRIVE_US * (CLK_KHZ / 1000);
  localparam int unsigned CLEAR_US_FAST    = 20;
  localparam int unsigned CLEAR_US_SLOW    = 24;
  localparam int unsigned TT_PHASE_US      = 4;
  localparam int unsigned NUM_DIGITS       = 12;

  // Register map, byte addresses.
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR  = 8'h08;

  // Control bit positions.
  localparam int unsigned CTRL_LONG_GAP  = 0;
  localparam int unsigned CTRL_TWO_DIGIT = 1;
  localparam int unsigned CTRL_FAST_CLR  = 2;

  // Event register bit positions (write one to pulse).
  localparam int unsigned EV_START_INSTR = 0;
  localparam int unsigned EV_SHORT_GAP   = 1;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0]  DIGIT_TOP  = 4'hC;

  // Readout sequence states.
  typedef enum logic [1:0] {
    TWS_RD_IDLE   = 2'b00,
    TWS_RD_FIRST  = 2'b01,
    TWS_RD_SECOND = 2'b10
  } tws_rd_state_t;

  // Pins from the tape transport and neighbouring controls.
  typedef struct packed {
    logic motion_start_pulse;
    logic first_block_flag;
    logic bad_spot_hold;
    logic gap_pause_set;
    logic gap_pause_clear;
    logic badspot_pause_set;
    logic badspot_pause_clear;
    logic ending_inhibit_set;
    logic ending_ready_reset;
    logic word_loaded_return;
    logic write_preset;
    logic write_cycle;
  } tws_pins_t;

  // Buffer driver outputs.
  typedef struct packed {
    logic [NUM_DIGITS-1:0] odd_reg_driver_fire;
    logic [NUM_DIGITS-1:0] even_reg_driver_fire;
  } tws_drv_t;

endpackage : tws_pkg

// ### tws_ctrl.sv
// Write-start control and output buffer read-driver sequencing for one tape synchronizer.
// What this block does
// (RULE1) Gap delay is 8.7 ms short gap, 22.7 ms long gap, from motion start.
// (RULE2) Motion start pulse samples gap mode and starts only the matching timer.
// (RULE3) Timer expiry sets tape-ready, except when starting from first block.
// (RULE4) Write-ready sets only with buffer-ready, tape-ready and start flag all set.
// (RULE5) Program issues start instruction after motion; immediately when over a gap.
// (RULE6) From first block program waits 1.6 s; late start overrides gap delay.
// (RULE7) First-block flag with bad-spot hold blocks the write start.
// (RULE8) Start pulse sets write-ready, driving write-active and write-operate.
// (RULE9) Start pulse clears start, buffer-ready, tape-ready and inhibit flags.
// (RULE10) Start pulse is one-shot, ending 0.5 us after it begins.
// (RULE11) Inhibit-write flag suppresses write-operate.
// (RULE12) Gap pause set and clear signals set and clear inhibit-write.
// (RULE13) Bad-spot pause set and clear signals set and clear inhibit-write.
// (RULE14) Ending signals set inhibit-write and reset write-ready.
// (RULE15) Each register has 12 drivers fired by 1 us clear or read pulses.
// (RULE16) Buffer-clear window enables all 24 clear gates for 24 us, or only the first 20 for 20 us.
// (RULE17) Clear gates step through the digit slots, one per 1 us phase.
// (RULE18) Decoded digit counter selects which read gate fires.
// (RULE19) Word-select blocks idle register and toggles after each full word.
// (RULE20) Each register has a two-digit-only gate and an always gate.
// (RULE21) Read at first phase; in two-digit mode read again after a counter step.
// (RULE22) Numeric order 12 down to 1; pairs 11,12 then 9,10 down to 1,2.
// (RULE23) Word-loaded return sets buffer-ready and requests the odd word.
// (RULE24) Write instruction with gap digit 0 selects short gap; digit 1 long.
//
// Decided for this implementation: the APB register port and the register offsets.
module tws_ctrl #(
  // Gap delays in clock cycles; a bench may shorten them to keep runs short.
  parameter int unsigned SHORT_GAP_CYCLES = tws_pkg::SHORT_GAP_CYCLES,
  parameter int unsigned LONG_GAP_CYCLES  = tws_pkg::LONG_GAP_CYCLES
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave.
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Transport and control pins.
  input  wire tws_pkg::tws_pins_t pins,
  // Outputs to the write path.
  output logic                  write_active,
  output logic                  write_operate,
  output logic                  write_start_pulse,
  output logic                  buffer_clear_window,
  output logic                  odd_word_request,
  output logic                  word_select,
  output logic [3:0]            digit_count_decode,
  output tws_pkg::tws_drv_t     drv
);

  // Two-flop synchronisers for every pin.
  tws_pkg::tws_pins_t pin_meta_reg;
  tws_pkg::tws_pins_t pin_sync_reg;
  tws_pkg::tws_pins_t pin_prev_reg;
  tws_pkg::tws_pins_t pin_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Edges are taken on the synchronised copy so a long pin level acts once.
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;

  // Control register and software event pulses.
  logic [31:0] ctrl_reg;
  logic        start_instr;
  logic        short_gap_instr;
  logic        apb_wr;
  logic        apb_rd;

  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;
  assign start_instr = apb_wr && paddr == tws_pkg::EVENT_ADDR
                       && pwdata[tws_pkg::EV_START_INSTR];
  assign short_gap_instr = apb_wr && paddr == tws_pkg::EVENT_ADDR
                           && pwdata[tws_pkg::EV_SHORT_GAP];

  // Control holds gap length, digit mode and fast clear variant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tws_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == tws_pkg::CTRL_ADDR) begin
      ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
    end
  end

  // Gap-mode flag: short gap set by instruction, cleared by write end.
  logic short_gap_reg;
  logic short_gap_selected;
  logic long_gap_selected;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_gap_reg <= 1'b0;
    end else if (short_gap_instr) begin
      short_gap_reg <= 1'b1; // [RULE24]
    end else if (pin_rise.ending_ready_reset) begin
      short_gap_reg <= 1'b0; // [RULE24]
    end
  end

  assign short_gap_selected = short_gap_reg;
  assign long_gap_selected  = !short_gap_reg;

  // Two delay timers, only the matching one started.
  logic [21:0] short_cnt_reg;
  logic [21:0] long_cnt_reg;
  logic        short_expire;
  logic        long_expire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_cnt_reg <= '0;
    end else if (pin_rise.motion_start_pulse && short_gap_selected) begin
      short_cnt_reg <= 22'(SHORT_GAP_CYCLES); // [RULE1] [RULE2]
    end else if (short_cnt_reg != '0) begin
      short_cnt_reg <= short_cnt_reg - 22'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_cnt_reg <= '0;
    end else if (pin_rise.motion_start_pulse && long_gap_selected) begin
      long_cnt_reg <= 22'(LONG_GAP_CYCLES); // [RULE1] [RULE2]
    end else if (long_cnt_reg != '0) begin
      long_cnt_reg <= long_cnt_reg - 22'd1;
    end
  end

  assign short_expire = short_cnt_reg == 22'd1;
  assign long_expire  = long_cnt_reg == 22'd1;

  // Flags and the one-shot start.
  logic tape_ready_reg;
  logic buf_ready_reg;
  logic rw_start_reg;
  logic inhibit_reg;
  logic ready_reg;
  logic [5:0] pulse_cnt_reg;
  logic start_cond;
  logic start_fire;

  // Start fires once; write-ready being set blocks a second pulse.
  assign start_cond = buf_ready_reg && tape_ready_reg && rw_start_reg // [RULE4]
                      && !(pin_sync_reg.first_block_flag && pin_sync_reg.bad_spot_hold); // [RULE7]
  assign start_fire = start_cond && !ready_reg; // [RULE10]

  // Tape-ready: set on expiry outside first block; a late start covers first block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tape_ready_reg <= 1'b0;
    end else if ((short_expire || long_expire) && !pin_sync_reg.first_block_flag) begin
      tape_ready_reg <= 1'b1; // [RULE3]
    end else if (start_instr && pin_sync_reg.first_block_flag) begin
      tape_ready_reg <= 1'b1; // [RULE6]
    end else if (start_fire) begin
      tape_ready_reg <= 1'b0; // [RULE9]
    end
  end

  // Program start flag; in first block the instruction itself stands for tape-ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_start_reg <= 1'b0;
    end else if (start_instr) begin
      rw_start_reg <= 1'b1; // [RULE5] [RULE6]
    end else if (start_fire) begin
      rw_start_reg <= 1'b0; // [RULE9]
    end
  end

  // Buffer-ready set by the loaded return; also requests the odd word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ready_reg    <= 1'b0;
      odd_word_request <= 1'b0;
    end else begin
      odd_word_request <= pin_rise.word_loaded_return; // [RULE23]
      if (pin_rise.word_loaded_return) begin
        buf_ready_reg <= 1'b1; // [RULE23]
      end else if (start_fire) begin
        buf_ready_reg <= 1'b0; // [RULE9]
      end
    end
  end

  // Inhibit-write: set wins over clear so a stop is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_reg <= 1'b0;
    end else if (pin_rise.gap_pause_set || pin_rise.badspot_pause_set // [RULE12] [RULE13]
                 || pin_rise.ending_inhibit_set) begin
      inhibit_reg <= 1'b1; // [RULE14]
    end else if (start_fire || pin_rise.gap_pause_clear // [RULE9] [RULE12]
                 || pin_rise.badspot_pause_clear) begin
      inhibit_reg <= 1'b0; // [RULE13]
    end
  end

  // Write-ready flag and the 0.5 us start pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg     <= 1'b0;
      pulse_cnt_reg <= '0;
    end else begin
      if (start_fire) begin
        ready_reg <= 1'b1; // [RULE8]
      end else if (pin_rise.ending_ready_reset) begin
        ready_reg <= 1'b0; // [RULE14]
      end
      if (start_fire) begin
        pulse_cnt_reg <= 6'(tws_pkg::START_CYCLES); // [RULE10]
      end else if (pulse_cnt_reg != '0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 6'd1;
      end
    end
  end

  // Registered outputs of the write-operate group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_active      <= 1'b0;
      write_operate     <= 1'b0;
      write_start_pulse <= 1'b0;
    end else begin
      write_active      <= ready_reg; // [RULE8]
      write_operate     <= ready_reg && !inhibit_reg; // [RULE11]
      write_start_pulse <= start_fire || pulse_cnt_reg > 6'd1; // [RULE10]
    end
  end

  // Buffer clear: window opens on write preset and steps one digit slot each 1 us.
  logic [11:0] clr_cnt_reg;
  logic [11:0] clr_len;
  logic [4:0]  clr_slot;

  // The fast variant shortens the window; slot advances once per 1 us phase.
  assign clr_len  = ctrl_reg[tws_pkg::CTRL_FAST_CLR]
                    ? 12'(tws_pkg::CLEAR_US_FAST * tws_pkg::DRIVE_CYCLES)
                    : 12'(tws_pkg::CLEAR_US_SLOW * tws_pkg::DRIVE_CYCLES);
  assign clr_slot = 5'((clr_len - clr_cnt_reg) / 12'(tws_pkg::DRIVE_CYCLES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_cnt_reg         <= '0;
      buffer_clear_window <= 1'b0;
    end else begin
      if (pin_rise.write_preset && clr_cnt_reg == '0) begin
        clr_cnt_reg <= clr_len; // [RULE16]
      end else if (clr_cnt_reg != '0) begin
        clr_cnt_reg <= clr_cnt_reg - 12'd1;
      end
      buffer_clear_window <= clr_cnt_reg != '0; // [RULE16]
    end
  end

  // Readout sequencer: one readout, then in two-digit mode a second after a step.
  tws_pkg::tws_rd_state_t rd_state_reg;
  logic [3:0] digit_reg;
  logic [6:0] drive_cnt_reg;
  logic       two_digit_mode;

  assign two_digit_mode = ctrl_reg[tws_pkg::CTRL_TWO_DIGIT]; // [RULE20]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state_reg  <= tws_pkg::TWS_RD_IDLE;
      digit_reg     <= tws_pkg::DIGIT_TOP;
      drive_cnt_reg <= '0;
      word_select   <= 1'b0;
    end else begin
      if (drive_cnt_reg != '0) begin
        drive_cnt_reg <= drive_cnt_reg - 7'd1;
      end
      case (rd_state_reg)
        tws_pkg::TWS_RD_IDLE: begin
          if (pin_rise.write_cycle && write_operate) begin
            rd_state_reg  <= tws_pkg::TWS_RD_FIRST; // [RULE21]
            drive_cnt_reg <= 7'(tws_pkg::DRIVE_CYCLES);
            if (two_digit_mode) begin
              digit_reg <= digit_reg - 4'd1; // [RULE22]
            end
          end
        end
        tws_pkg::TWS_RD_FIRST: begin
          if (drive_cnt_reg == 7'd1) begin
            if (two_digit_mode) begin
              // Pair order: low digit first, then step up to its partner.
              digit_reg     <= digit_reg + 4'd1; // [RULE21] [RULE22]
              rd_state_reg  <= tws_pkg::TWS_RD_SECOND;
              drive_cnt_reg <= 7'(tws_pkg::DRIVE_CYCLES);
            end else begin
              rd_state_reg <= tws_pkg::TWS_RD_IDLE;
              if (digit_reg == 4'd1) begin
                digit_reg   <= tws_pkg::DIGIT_TOP;
                word_select <= !word_select; // [RULE19]
              end else begin
                digit_reg <= digit_reg - 4'd1; // [RULE22]
              end
            end
          end
        end
        tws_pkg::TWS_RD_SECOND: begin
          if (drive_cnt_reg == 7'd1) begin
            rd_state_reg <= tws_pkg::TWS_RD_IDLE;
            if (digit_reg == 4'd2) begin
              digit_reg   <= tws_pkg::DIGIT_TOP;
              word_select <= !word_select; // [RULE19]
            end else begin
              digit_reg <= digit_reg - 4'd2; // [RULE22]
            end
          end
        end
        default: begin
          rd_state_reg <= tws_pkg::TWS_RD_IDLE;
        end
      endcase
    end
  end

  // Driver decode: each clear slot fires one gate of the odd or even register, read fires the active one.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv                <= '0;
      digit_count_decode <= tws_pkg::DIGIT_TOP;
    end else begin
      digit_count_decode <= digit_reg; // [RULE18]
      for (int i = 0; i < tws_pkg::NUM_DIGITS; i++) begin
        // Clear gates: slots 0 to 11 fire the odd register, later slots the even one.
        drv.odd_reg_driver_fire[i] <=
          (clr_cnt_reg != '0 && 32'(clr_slot) == i) // [RULE15] [RULE17]
          || (rd_state_reg != tws_pkg::TWS_RD_IDLE && word_select // [RULE19]
              && 32'(digit_reg) == i + 1); // [RULE18]
        drv.even_reg_driver_fire[i] <=
          (clr_cnt_reg != '0 && 32'(clr_slot) == i + tws_pkg::NUM_DIGITS) // [RULE17]
          || (rd_state_reg != tws_pkg::TWS_RD_IDLE && !word_select
              && 32'(digit_reg) == i + 1); // [RULE15] [RULE18]
      end
    end
  end

  // APB slave: zero wait, reads decoded in setup and held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != tws_pkg::CTRL_ADDR
                 && paddr != tws_pkg::STATUS_ADDR && paddr != tws_pkg::EVENT_ADDR;
      if (apb_rd) begin
        case (paddr)
          tws_pkg::CTRL_ADDR:   prdata <= ctrl_reg;
          tws_pkg::STATUS_ADDR: prdata <= {20'h0_0000, digit_reg, word_select,
                                           short_gap_reg, inhibit_reg, ready_reg,
                                           rw_start_reg, tape_ready_reg,
                                           buf_ready_reg, buffer_clear_window};
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // tws_ctrl

// ### tws_ctrl_props.sv
// Concurrent checks on the ports of the write-start and readout control.
module tws_ctrl_props (
  // Clock and reset.
  input wire logic               pclk,
  input wire logic               presetn,
  // Transport and neighbouring control pins.
  input wire tws_pkg::tws_pins_t pins,
  // Write path outputs.
  input wire logic               write_active,
  input wire logic               write_operate,
  input wire logic               write_start_pulse,
  input wire logic               buffer_clear_window,
  input wire logic               odd_word_request,
  input wire logic [3:0]         digit_count_decode,
  input wire tws_pkg::tws_drv_t  drv
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned       sp_cnt;
  int unsigned       cw_cnt;
  int unsigned       dr_cnt;
  tws_pkg::tws_drv_t drv_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Run lengths of the start pulse, the clear window and each driver value.
  // Counting beats a long repetition, which the tools would have to unroll.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_cnt <= 0;
      cw_cnt <= 0;
      dr_cnt <= 0;
      drv_q  <= '0;
    end else begin
      sp_cnt <= write_start_pulse ? sp_cnt + 1 : 0;
      cw_cnt <= buffer_clear_window ? cw_cnt + 1 : 0;
      dr_cnt <= (drv != drv_q) ? 1 : dr_cnt + 1;
      drv_q  <= drv;
    end
  end

  start_len_a: assert property (
    $fell(write_start_pulse) |-> sp_cnt == tws_pkg::START_CYCLES)
    else $error("start pulse length wrong");
  start_once_a: assert property (
    $rose(write_start_pulse) |=> write_active && !$past(write_active))
    else $error("start pulse without fresh write ready");
  operate_ready_a: assert property (
    write_operate |-> write_active)
    else $error("write operate without write ready");
  clear_len_a: assert property (
    $fell(buffer_clear_window) |-> cw_cnt == 2400 || cw_cnt == 2000)
    else $error("clear window length wrong");
  drive_len_a: assert property (
    (drv != drv_q && drv_q != '0) |-> dr_cnt == 100)
    else $error("driver pulse not 1 us");
  one_driver_a: assert property (
    $onehot0(drv))
    else $error("more than one driver fired");
  digit_range_a: assert property (
    digit_count_decode inside {[4'h1:4'hC]})
    else $error("digit count out of range");
  gap_pause_a: assert property (
    $rose(pins.gap_pause_set) |-> ##[1:6] !write_operate)
    else $error("gap pause did not stop writing");
  bad_pause_a: assert property (
    $rose(pins.badspot_pause_set) |-> ##[1:6] !write_operate)
    else $error("bad spot pause did not stop writing");
  end_ready_a: assert property (
    $rose(pins.ending_ready_reset) |-> ##[1:6] !write_active)
    else $error("ending did not drop write ready");
  odd_request_a: assert property (
    $rose(pins.word_loaded_return) |-> ##[1:6] odd_word_request)
    else $error("odd word not requested");
endmodule // tws_ctrl_props

bind tws_ctrl tws_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .pins(pins), .write_active(write_active),
  .write_operate(write_operate), .write_start_pulse(write_start_pulse),
  .buffer_clear_window(buffer_clear_window), .odd_word_request(odd_word_request),
  .digit_count_decode(digit_count_decode), .drv(drv)
);

// ### tws_tape_model.sv
// Tape transport model that drives the transport and neighbouring control pins.
module tws_tape_model (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Tape moving under the head, from the bench.
  input  wire logic               run,
  // Pins to the block.
  output tws_pkg::tws_pins_t      pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // First-block and bad-spot levels stay low: the write starts over a gap.
  logic [10:0] ev_q   = '0;
  logic        wc_q   = 1'b0;
  int unsigned wc_cnt = 0;

  assign pins = {ev_q, wc_q};

  // An event line is held for several edges so the two-flop sync sees it.
  task automatic pulse(input int i);
    @(posedge pclk);
    ev_q[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    ev_q[i] <= 1'b0;
  endtask

  // Tape-write cycle every 48 us, high for 4 us, only while tape moves.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wc_cnt <= 0;
      wc_q   <= 1'b0;
    end else begin
      wc_cnt <= (run && wc_cnt < 4799) ? wc_cnt + 1 : 0;
      wc_q   <= run && wc_cnt < 400;
    end
  end
endmodule // tws_tape_model

// ### tb_tws_ctrl.sv
// Self-checking bench for the write-start and readout control.
module tb_tws_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // Event line positions in the model's event vector.
  localparam int MOTION = 10, GSET = 7, GCLR = 6, BSET = 5, BCLR = 4;
  localparam int EINH = 3, ERDY = 2, LOADED = 1, PRESET = 0;
  // Gap delays are cut by this factor so the run stays short.
  localparam int unsigned GAP_DIV = 1000;
  logic               pclk, presetn, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic               pready, pslverr, err, run = 1'b0, mon_on = 1'b0;
  logic               write_active, write_operate, write_start_pulse;
  logic               buffer_clear_window, odd_word_request, word_select;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic [3:0]         digit_count_decode;
  logic [23:0]        cov;
  tws_pkg::tws_pins_t pins;
  tws_pkg::tws_drv_t  drv, drv_prev = '0;
  int                 errors = 0, checks_done = 0, n, e;
  int                 seen_q[$];
  time                t0;

  tws_ctrl #(.SHORT_GAP_CYCLES(tws_pkg::SHORT_GAP_CYCLES / GAP_DIV),
    .LONG_GAP_CYCLES(tws_pkg::LONG_GAP_CYCLES / GAP_DIV))
    uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .write_active(write_active),
    .write_operate(write_operate), .write_start_pulse(write_start_pulse),
    .buffer_clear_window(buffer_clear_window), .odd_word_request(odd_word_request),
    .word_select(word_select), .digit_count_decode(digit_count_decode), .drv(drv));
  tws_tape_model m (.pclk(pclk), .presetn(presetn), .run(run), .pins(pins));

  // 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (!pready);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Record each newly fired read driver once the write is running.
  always @(posedge pclk) begin
    drv_prev <= drv;
    if (mon_on && drv != drv_prev && drv != '0) begin
      for (int j = 0; j < 24; j++) begin
        if (drv[j]) seen_q.push_back(j);
      end
    end
  end

  // About 18 tape-write cycles of readout dominate the run; this leaves a margin.
  initial begin
    #1_000_000;
    errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, tws_pkg::CTRL_ADDR, 0);
    chk("ctrl", rd, tws_pkg::CTRL_RESET);
    apb(0, tws_pkg::STATUS_ADDR, 0);
    chk("status", rd, {20'h0, tws_pkg::DIGIT_TOP, 8'h00});
    apb(0, 8'h0C, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    // Slow and fast clear windows, with driver coverage of the slow one.
    for (int f = 0; f < 2; f++) begin
      apb(1, tws_pkg::CTRL_ADDR, f << tws_pkg::CTRL_FAST_CLR);
      fork m.pulse(PRESET); join_none
      cov = '0;
      for (n = 0; n < 200 && !buffer_clear_window; n++) @(posedge pclk);
      for (n = 0; n < 3000 && buffer_clear_window; n++) begin
        cov |= drv;
        @(posedge pclk);
      end
      e = (f ? tws_pkg::CLEAR_US_FAST : tws_pkg::CLEAR_US_SLOW) * 100;
      chk("clear_len", n, e);
      if (f == 0) chk("clear_cover", cov, 24'hFF_FFFF);
    end
    apb(1, tws_pkg::CTRL_ADDR, 0);
    fork m.pulse(LOADED); join_none
    for (n = 0; n < 12 && !odd_word_request; n++) @(posedge pclk);
    chk("odd_request", odd_word_request, 1'b1);
    apb(0, tws_pkg::STATUS_ADDR, 0);
    chk("buf_ready", rd[1], 1'b1);
    apb(1, tws_pkg::EVENT_ADDR, 32'h2);
    apb(0, tws_pkg::STATUS_ADDR, 0);
    chk("short_gap", rd[6], 1'b1);
    // Motion starts and the program issues the start at once.
    fork m.pulse(MOTION); join_none
    t0 = $time;
    apb(1, tws_pkg::EVENT_ADDR, 32'h1);
    apb(0, tws_pkg::STATUS_ADDR, 0);
    chk("start_flag", rd[3:2], 2'b10);
    chk("no_early_start", write_active, 1'b0);
    for (n = 0; n < 900000 && !write_start_pulse; n++) @(posedge pclk);
    n = int'(($time - t0) / 10);
    e = tws_pkg::SHORT_GAP_CYCLES / GAP_DIV;
    chk("gap_delay", n >= e && n <= e + 12, 1'b1);
    repeat (2) @(posedge pclk);
    chk("started", {write_active, write_operate}, 2'b11);
    apb(0, tws_pkg::STATUS_ADDR, 0);
    chk("start_clears", rd[5:1], 5'b01000);
    // Numeric word from the even register, then a pair word from the odd one.
    run    <= 1'b1;
    mon_on <= 1'b1;
    for (n = 0; n < 70000 && seen_q.size() < 12; n++) @(posedge pclk);
    for (n = 0; n < 4800 && !word_select; n++) @(posedge pclk);
    chk("word_select", word_select, 1'b1);
    apb(1, tws_pkg::CTRL_ADDR, 32'h2);
    for (n = 0; n < 40000 && seen_q.size() < 24; n++) @(posedge pclk);
    run <= 1'b0;
    for (int k = 0; k < 24; k++) begin
      e = (k < 12) ? 11 - k : 22 - 2 * ((k - 12) / 2) + k % 2;
      chk("digit_order", (seen_q.size() > k) ? seen_q[k] : -1, e);
    end
    // Pause and resume by the gap controls, then by the bad-spot controls.
    for (int p = 0; p < 2; p++) begin
      fork m.pulse(p ? BSET : GSET); join_none
      for (n = 0; n < 12 && write_operate; n++) @(posedge pclk);
      chk("paused", {write_active, write_operate}, 2'b10);
      fork m.pulse(p ? BCLR : GCLR); join_none
      for (n = 0; n < 12 && !write_operate; n++) @(posedge pclk);
      chk("resumed", {write_active, write_operate}, 2'b11);
    end
    fork m.pulse(EINH); join_none
    for (n = 0; n < 12 && write_operate; n++) @(posedge pclk);
    chk("end_inhibit", {write_active, write_operate}, 2'b10);
    fork m.pulse(ERDY); join_none
    for (n = 0; n < 12 && write_active; n++) @(posedge pclk);
    chk("end_ready", {write_active, write_operate}, 2'b00);
    end_sim();
  end
endmodule // tb_tws_ctrl
